// ### design/dfs_pkg.sv
package dfs_pkg;
   // array geometry: four blocks of 8 KB, 32 KB in all
   localparam int unsigned DFS_BLOCK_BYTES = 8192;
   localparam int unsigned DFS_NUM_BLOCKS = 4;
   localparam int unsigned DFS_ARRAY_BYTES = DFS_BLOCK_BYTES * DFS_NUM_BLOCKS;
   localparam int unsigned DFS_ADDR_W = $clog2(DFS_ARRAY_BYTES);
   localparam int unsigned DFS_BLK_W = $clog2(DFS_NUM_BLOCKS);
   localparam int unsigned DFS_WORD_BYTES = 8;
   localparam int unsigned DFS_WORD_ADDR_W = DFS_ADDR_W - 3;
   localparam int unsigned DFS_BLOCK_WORDS = DFS_BLOCK_BYTES / DFS_WORD_BYTES;
   // unit sizes in bytes
   localparam int unsigned DFS_BC_SMALL_BYTES = 8;
   localparam int unsigned DFS_PROG_SMALL_BYTES = 8;
   localparam int unsigned DFS_PROG_MID_BYTES = 128;
   localparam int unsigned DFS_PROG_BOOT_BYTES = 256;
   // cell timing in ns, at a 10 ns clock
   localparam int unsigned DFS_CLK_NS = 10;
   localparam int unsigned DFS_ERASE_NS = 1000;
   localparam int unsigned DFS_ERASE_CYC =
      (DFS_ERASE_NS + DFS_CLK_NS - 1) / DFS_CLK_NS;
   localparam int unsigned DFS_CNT_W = 16;

   // command codes
   typedef enum logic [1:0] {
      DFS_CMD_BLANK,
      DFS_CMD_ERASE,
      DFS_CMD_PROG
   } dfs_cmd_e;

   // size selectors carried with a command
   localparam logic [1:0] DFS_SZ_SMALL = 2'h0; // 8 bytes
   localparam logic [1:0] DFS_SZ_LARGE = 2'h1; // block, or 128 bytes
   // operating modes
   localparam logic DFS_MODE_USER = 1'h0;
   localparam logic DFS_MODE_BOOT = 1'h1;
endpackage : dfs_pkg

// ### design/dfs_sequencer.sv
`timescale 1ns/1ps
// Notes on behaviour
// - 32 KB array in four 8 KB blocks
// - erased cells read back undefined, not fixed
// - blank check tests area, updates result status
// - blank check covers 8 bytes or one block
// - erase clears exactly one whole block
// - ready flag drops in the same cycle erase begins
// - ready flag rises when erase finishes
// - user modes program 8 or 128 bytes
// - boot mode programs 256 bytes
// - ready low through programming, then high
// - operations run alone once commanded
// - main flash fetches served during operations
module dfs_sequencer
   import dfs_pkg::*;
#(
   parameter int unsigned ERASE_CYCLES = DFS_ERASE_CYC
) (
   input wire logic ref_clk,
   input wire logic rst_b,
   // command port
   input wire logic cmd_valid,
   input wire logic [1:0] cmd_code,
   input wire logic [1:0] cmd_size,
   input wire logic [DFS_ADDR_W-1:0] cmd_addr,
   input wire logic boot_mode,
   // write data stream, one 8-byte word per beat while programming
   input wire logic [63:0] wr_data,
   output logic wr_take,
   // data flash read port
   input wire logic [DFS_ADDR_W-1:0] rd_addr,
   output logic [63:0] rd_data,
   // main flash fetch port, independent of the sequencer
   input wire logic [DFS_ADDR_W-1:0] fetch_addr,
   output logic [63:0] fetch_data,
   // status
   output logic sequencer_ready_flag,
   output logic blank_check_result_status,
   output logic bc_done
);

   typedef enum logic [1:0] {
      DFS_IDLE,
      DFS_BLANK,
      DFS_ERASE,
      DFS_PROG
   } dfs_state_e;

   localparam int unsigned WORDS = DFS_ARRAY_BYTES / DFS_WORD_BYTES;
   localparam logic [DFS_WORD_ADDR_W-1:0] BLK_LAST =
      DFS_WORD_ADDR_W'(DFS_BLOCK_WORDS - 1);
   localparam logic [DFS_WORD_ADDR_W-1:0] W_SMALL =
      DFS_WORD_ADDR_W'(DFS_PROG_SMALL_BYTES / DFS_WORD_BYTES - 1);
   localparam logic [DFS_WORD_ADDR_W-1:0] W_MID =
      DFS_WORD_ADDR_W'(DFS_PROG_MID_BYTES / DFS_WORD_BYTES - 1);
   localparam logic [DFS_WORD_ADDR_W-1:0] W_BOOT =
      DFS_WORD_ADDR_W'(DFS_PROG_BOOT_BYTES / DFS_WORD_BYTES - 1);
   localparam logic [DFS_WORD_ADDR_W-1:0] W_BC_SMALL =
      DFS_WORD_ADDR_W'(DFS_BC_SMALL_BYTES / DFS_WORD_BYTES - 1);
   localparam logic [DFS_CNT_W-1:0] ERASE_LAST =
      DFS_CNT_W'(ERASE_CYCLES - 1);

   dfs_state_e state_q;
   logic [63:0] cell_q [WORDS];        // data cells
   logic [WORDS-1:0] prog_q;           // complementary pair written
   logic [63:0] main_q [WORDS];        // main flash image, read only here
   logic [DFS_WORD_ADDR_W-1:0] ptr_q;  // current word
   logic [DFS_WORD_ADDR_W-1:0] left_q; // words left after current
   logic [DFS_BLK_W-1:0] blk_q;
   logic [DFS_CNT_W-1:0] tmr_q;
   logic blank_acc_q;
   logic ready_q;
   logic bc_res_q;
   logic bc_done_q;
   logic [63:0] rd_q;
   logic [63:0] fetch_q;
   logic start;
   logic [DFS_WORD_ADDR_W-1:0] prog_len;

   //////////////////////////////////////////////////////////////////////
   // command acceptance; host must wait for ready, so busy drops it
   assign start = cmd_valid && ready_q;
   assign wr_take = (state_q == DFS_PROG);

   // program length from operating mode and size selector
   always_comb begin
      if (boot_mode == DFS_MODE_BOOT) begin
         prog_len = W_BOOT;
      end else if (cmd_size == DFS_SZ_LARGE) begin
         prog_len = W_MID;
      end else begin
         prog_len = W_SMALL;
      end
   end

   //////////////////////////////////////////////////////////////////////
   // sequencer state; runs without the host once started
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         state_q <= DFS_IDLE;
      end else begin
         case (state_q)
            DFS_IDLE: begin
               if (start) begin
                  if (cmd_code == DFS_CMD_BLANK) begin
                     state_q <= DFS_BLANK;
                  end else if (cmd_code == DFS_CMD_ERASE) begin
                     state_q <= DFS_ERASE;
                  end else if (cmd_code == DFS_CMD_PROG) begin
                     state_q <= DFS_PROG;
                  end
               end
            end
            DFS_BLANK: if (left_q == '0) state_q <= DFS_IDLE;
            DFS_ERASE: if (tmr_q == ERASE_LAST) state_q <= DFS_IDLE;
            DFS_PROG: if (left_q == '0) state_q <= DFS_IDLE;
            default: state_q <= DFS_IDLE;
         endcase
      end
   end

   // ready flag: low from acceptance until the last cycle of work
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         ready_q <= 1'h1;
      end else if (start && (cmd_code == DFS_CMD_BLANK ||
                   cmd_code == DFS_CMD_ERASE || cmd_code == DFS_CMD_PROG)) begin
         ready_q <= 1'h0;
      end else if (state_q != DFS_IDLE && state_q != DFS_ERASE &&
                   left_q == '0) begin
         ready_q <= 1'h1;
      end else if (state_q == DFS_ERASE && tmr_q == ERASE_LAST) begin
         ready_q <= 1'h1;
      end
   end

   //////////////////////////////////////////////////////////////////////
   // address walk: pointer, words remaining, erase timer
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         ptr_q <= '0;
         left_q <= '0;
         blk_q <= '0;
         tmr_q <= '0;
      end else if (start) begin
         blk_q <= cmd_addr[DFS_ADDR_W-1 -: DFS_BLK_W];
         tmr_q <= '0;
         if (cmd_code == DFS_CMD_BLANK && cmd_size == DFS_SZ_LARGE) begin
            // block check starts at the block base
            ptr_q <= {cmd_addr[DFS_ADDR_W-1 -: DFS_BLK_W],
                      {(DFS_WORD_ADDR_W-DFS_BLK_W){1'b0}}};
            left_q <= BLK_LAST;
         end else if (cmd_code == DFS_CMD_BLANK) begin
            ptr_q <= cmd_addr[DFS_ADDR_W-1:3];
            left_q <= W_BC_SMALL;
         end else begin
            // program units align down to their own size
            ptr_q <= cmd_addr[DFS_ADDR_W-1:3] & ~prog_len;
            left_q <= prog_len;
         end
      end else if (state_q == DFS_ERASE) begin
         tmr_q <= tmr_q + 1'b1;
      end else if (state_q != DFS_IDLE && left_q != '0) begin
         ptr_q <= ptr_q + 1'b1;
         left_q <= left_q - 1'b1;
      end
   end

   //////////////////////////////////////////////////////////////////////
   // blank check accumulates over the area, then posts the result
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         blank_acc_q <= 1'h1;
         bc_res_q <= 1'h0;
         bc_done_q <= 1'h0;
      end else begin
         bc_done_q <= 1'h0;
         if (start) begin
            blank_acc_q <= 1'h1;
         end else if (state_q == DFS_BLANK) begin
            blank_acc_q <= blank_acc_q & ~prog_q[ptr_q];
            if (left_q == '0) begin
               bc_res_q <= ~(blank_acc_q & ~prog_q[ptr_q]);
               bc_done_q <= 1'h1;
            end
         end
      end
   end

   //////////////////////////////////////////////////////////////////////
   // cell array: erase marks the whole block unwritten at its end,
   // program stores one word per cycle; erased cells hold stale data
   // since the complementary pair reads back undefined
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         prog_q <= '0;
      end else if (state_q == DFS_ERASE && tmr_q == ERASE_LAST) begin
         for (int i = 0; i < WORDS; i++) begin
            if (i / DFS_BLOCK_WORDS == int'(blk_q)) begin
               prog_q[i] <= 1'b0;
            end
         end
      end else if (state_q == DFS_PROG) begin
         prog_q[ptr_q] <= 1'b1;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (state_q == DFS_PROG) begin
         cell_q[ptr_q] <= wr_data;
      end
   end

   //////////////////////////////////////////////////////////////////////
   // read ports; fetch path has no tie to the sequencer state
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         rd_q <= '0;
         fetch_q <= '0;
      end else begin
         rd_q <= cell_q[rd_addr[DFS_ADDR_W-1:3]];
         fetch_q <= main_q[fetch_addr[DFS_ADDR_W-1:3]];
      end
   end

   // main image is loaded elsewhere; here it simply holds zeros
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         for (int i = 0; i < WORDS; i++) begin
            main_q[i] <= '0;
         end
      end
   end

   assign rd_data = rd_q;
   assign fetch_data = fetch_q;
   assign sequencer_ready_flag = ready_q;
   assign blank_check_result_status = bc_res_q;
   assign bc_done = bc_done_q;

endmodule : dfs_sequencer

// ### bench/dfs_seq_properties.sv
`timescale 1ns/1ps
module dfs_seq_properties
   import dfs_pkg::*;
#(
   parameter int unsigned ERASE_CYCLES = DFS_ERASE_CYC
) (
   input wire logic ref_clk,
   input wire logic rst_b,
   input wire logic cmd_valid,
   input wire logic [1:0] cmd_code,
   input wire logic [1:0] cmd_size,
   input wire logic boot_mode,
   input wire logic wr_take,
   input wire logic [63:0] fetch_data,
   input wire logic sequencer_ready_flag,
   input wire logic blank_check_result_status,
   input wire logic bc_done
);
   localparam int EC1 = ERASE_CYCLES - 1;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_b);
   // taken commands, split by kind
   wire rdy = sequencer_ready_flag;
   wire go = cmd_valid && rdy;
   wire er = go && cmd_code == 2'h1;
   wire pg = go && cmd_code == 2'h2;
   wire bc = go && cmd_code == 2'h0 && cmd_size == 2'h0;
   wire pg_small = pg && !boot_mode && cmd_size == 2'h0;
   wire pg_large = pg && !boot_mode && cmd_size == 2'h1;
   // one-word program: a single take, then ready again
   sequence fill1;
      (wr_take && !rdy) ##1 (rdy && !wr_take);
   endsequence
   // one-word blank check: busy one cycle, then result with ready
   sequence blank1;
      (!rdy && !bc_done) ##1 (rdy && bc_done);
   endsequence
   sequence erase_run;
      (!rdy throughout ##EC1 1'b1) ##1 rdy;
   endsequence
   sequence fill16;
      ((wr_take && !rdy) throughout ##15 1'b1) ##1 (rdy && !wr_take);
   endsequence
   sequence fill32;
      ((wr_take && !rdy) throughout ##31 1'b1) ##1 (rdy && !wr_take);
   endsequence
   ready_drop_a: assert property (go && cmd_code != 2'h3 |=> !rdy)
      else $error("ready did not fall on a command");
   erase_time_a: assert property (er |=> erase_run)
      else $error("erase busy time wrong");
   prog_small_a: assert property (pg_small |=> fill1)
      else $error("small program length wrong");
   prog_large_a: assert property (pg_large |=> fill16)
      else $error("large program length wrong");
   prog_boot_a: assert property (pg && boot_mode |=> fill32)
      else $error("boot program length wrong");
   blank_small_a: assert property (bc |=> blank1)
      else $error("small blank check timing wrong");
   done_pulse_a: assert property (bc_done |=> !bc_done)
      else $error("blank done longer than one cycle");
   status_hold_a: assert property ($past(rst_b) && !bc_done |->
      $stable(blank_check_result_status))
      else $error("blank result moved without done");
   take_busy_a: assert property (wr_take |-> !rdy)
      else $error("data taken while ready");
   fetch_serve_a: assert property (!rdy |-> fetch_data == 64'h0)
      else $error("fetch disturbed while busy");
endmodule : dfs_seq_properties

// ### bench/dfs_host_model.sv
`timescale 1ns/1ps
module dfs_host_model
   import dfs_pkg::*;
(
   input wire logic ref_clk,
   input wire logic sequencer_ready_flag,
   output logic cmd_valid,
   output logic [1:0] cmd_code,
   output logic [1:0] cmd_size,
   output logic [DFS_ADDR_W-1:0] cmd_addr,
   output logic [63:0] wr_data
);
   initial begin
      cmd_valid = 1'b0;
      cmd_code = 2'h3;
      cmd_size = 2'h0;
      cmd_addr = '0;
   end
   // fresh data each cycle, so a stale word never passes for a good one
   always @(posedge ref_clk) wr_data <= {$urandom, $urandom};
   // lag makes a slow host; size chosen by the host
   task automatic issue(input logic [1:0] c, input logic [1:0] s,
         input logic [DFS_ADDR_W-1:0] a, input int lag);
      int n;
      n = 0;
      repeat (lag) @(posedge ref_clk);
      while (sequencer_ready_flag !== 1'b1 && n < 4000) begin
         @(negedge ref_clk);
         n++;
      end
      @(posedge ref_clk);
      cmd_valid <= 1'b1;
      cmd_code <= c;
      cmd_size <= s;
      cmd_addr <= a;
      @(posedge ref_clk);
      cmd_valid <= 1'b0;
      cmd_code <= ~c;
      cmd_size <= ~s;
      cmd_addr <= ~a;
      do begin
         @(negedge ref_clk);
         n++;
      end while (sequencer_ready_flag !== 1'b1 && n < 8000);
   endtask : issue
endmodule : dfs_host_model

// ### bench/data_flash_sequencer_test.sv
`timescale 1ns/1ps
module data_flash_sequencer_test;
   import dfs_pkg::*;
   logic ref_clk = 1'b0, rst_b = 1'b0, boot_mode = 1'b0;
   logic [DFS_ADDR_W-1:0] rd_addr = '0, fetch_addr = '0, cmd_addr;
   logic cmd_valid, wr_take, sequencer_ready_flag;
   logic blank_check_result_status, bc_done;
   logic [1:0] cmd_code, cmd_size;
   logic [63:0] wr_data, rd_data, fetch_data;
   logic [63:0] mem [int];
   int bad_count = 0, tests_run = 0, cyc = 0, takes = 0, wa = 0;
   always #5 ref_clk = ~ref_clk;
   dfs_sequencer #(.ERASE_CYCLES(4)) dut (.ref_clk, .rst_b, .cmd_valid,
      .cmd_code, .cmd_size, .cmd_addr, .boot_mode, .wr_data, .wr_take,
      .rd_addr, .rd_data, .fetch_addr, .fetch_data, .sequencer_ready_flag,
      .blank_check_result_status, .bc_done);
   dfs_host_model host (.ref_clk, .sequencer_ready_flag, .cmd_valid,
      .cmd_code, .cmd_size, .cmd_addr, .wr_data);
   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      tests_run++;
      if (got !== exp) begin
         bad_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic summarize();
      if (bad_count == 0 && tests_run > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : summarize
   function automatic logic any_written(int w, int n);
      for (int i = w; i < w + n; i++)
         if (mem.exists(i)) return 1'b1;
      return 1'b0;
   endfunction : any_written
   // reference store follows every word taken; fetches keep running
   always @(posedge ref_clk) begin
      cyc++;
      fetch_addr <= DFS_ADDR_W'($urandom);
      if (rst_b && wr_take === 1'b1) begin
         mem[wa] = wr_data;
         wa++;
         takes++;
      end
      if (cyc == 40000) begin
         bad_count++;
         summarize();
      end
   end
   ////////////////////////////////////////////////////////////////////
   initial begin
      int junk, n, w, b;
      logic exp_bc;
      logic [DFS_ADDR_W-1:0] a;
      junk = $urandom(32'h99AE);
      repeat (16) @(posedge ref_clk);
      rst_b <= 1'b1;
      @(negedge ref_clk);
      chk(sequencer_ready_flag, 64'h1);
      chk(bc_done, 64'h0);
      // the spare code is taken but starts nothing
      host.issue(2'h3, 2'h0, '0, 0);
      chk(sequencer_ready_flag, 64'h1);
      chk(wr_take, 64'h0);
      chk(bc_done, 64'h0);
      // user small, user large, boot, twice with random places
      for (int i = 0; i < 6; i++) begin
         a = DFS_ADDR_W'($urandom);
         n = (i % 3 == 2) ? 32 : (i % 3 == 1) ? 16 : 1;
         w = int'(a >> 3) / n * n;
         b = int'(a >> 13);
         wa = w;
         takes = 0;
         @(posedge ref_clk);
         boot_mode <= (i % 3 == 2);
         host.issue(2'h2, 2'(i % 3 == 1 || i == 5), a, i);
         chk(takes, n);
         for (int k = 0; k < n; k++) begin
            @(posedge ref_clk);
            rd_addr <= DFS_ADDR_W'((w + k) * 8);
            @(posedge ref_clk);
            @(negedge ref_clk);
            chk(rd_data, mem[w + k]);
         end
         host.issue(2'h0, 2'h0, a, 0);
         chk(blank_check_result_status, 64'h1);
         host.issue(2'h1, 2'h0, a, 2);
         for (int j = b * 1024; j < b * 1024 + 1024; j++) mem.delete(j);
         host.issue(2'h0, 2'h1, a, 0);
         chk(bc_done, 64'h1);
         chk(blank_check_result_status, 64'h0);
         host.issue(2'h0, 2'h1, a ^ 15'h2000, 1);
         exp_bc = any_written((b ^ 1) * 1024, 1024);
         chk(blank_check_result_status, exp_bc);
      end
      summarize();
   end
endmodule : data_flash_sequencer_test
bind dfs_sequencer dfs_seq_properties #(.ERASE_CYCLES(ERASE_CYCLES)) chk (
   .ref_clk, .rst_b, .cmd_valid, .cmd_code, .cmd_size, .boot_mode,
   .wr_take, .fetch_data, .sequencer_ready_flag,
   .blank_check_result_status, .bc_done);
